// ### design/hsq_homing_seq.sv
module hsq_homing_seq
  import hsq_pkg::*;
(
  input  wire logic                   CLK_SYS_I,
  input  wire logic                   RST_I,
  input  wire logic                   START_I,
  input  wire logic [3:0]             METHOD_I,
  input  wire logic                   DECEL_VALID_I,
  input  wire logic [HSQ_SPEED_W-1:0] SPEED_HIGH_I,
  input  wire logic [HSQ_SPEED_W-1:0] SPEED_LOW_I,
  input  wire logic                   ORIGIN_SW_I,
  input  wire logic                   FWD_LIMIT_I,
  input  wire logic                   Z_PHASE_I,
  output logic                        RUN_O,
  output logic                        REVERSE_O,
  output logic [HSQ_SPEED_W-1:0]      SPEED_O,
  output logic                        BUSY_O,
  output logic                        DONE_O
);

  // ----------------------------------------
  // input edges
  // ----------------------------------------
  // inputs are synchronous; one register stage gives a clean previous value
  logic       org_q;
  logic       lim_q;
  logic       z_q;
  logic       is_m7;
  hsq_state_t state;
  hsq_state_t next_state;
  hsq_motion_t next_motion;

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      org_q <= 1'b0;
      lim_q <= 1'b0;
      z_q   <= 1'b0;
    end else begin
      org_q <= ORIGIN_SW_I;
      lim_q <= FWD_LIMIT_I;
      z_q   <= Z_PHASE_I;
    end
  end

  wire org_rise = ORIGIN_SW_I & ~org_q;
  wire org_fall = ~ORIGIN_SW_I & org_q;
  wire lim_rise = FWD_LIMIT_I & ~lim_q;
  wire z_rise   = Z_PHASE_I & ~z_q;
  wire start_ok = START_I & ((METHOD_I == HSQ_METHOD_7) | (METHOD_I == HSQ_METHOD_8));

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // method is latched at start so a change mid-run cannot reroute the walk
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      is_m7 <= 1'b0;
    end else if (state == HSQ_IDLE && start_ok) begin
      is_m7 <= (METHOD_I == HSQ_METHOD_7);
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      HSQ_IDLE: begin
        if (start_ok) begin
          if (METHOD_I == HSQ_METHOD_8 && DECEL_VALID_I) begin
            next_state = HSQ_REV_LOW;
          end else begin
            next_state = HSQ_FWD_HIGH;
          end
        end
      end
      HSQ_FWD_HIGH: begin
        if (org_rise) begin
          next_state = is_m7 ? HSQ_REV_HIGH : HSQ_REV_LOW;
        end else if (lim_rise && is_m7) begin
          next_state = HSQ_REV_HIGH;
        end
      end
      HSQ_REV_HIGH: begin
        if (org_rise) begin
          next_state = HSQ_REV_LOW;
        end
      end
      HSQ_REV_LOW: begin
        if (org_fall) begin
          next_state = is_m7 ? HSQ_SEEK_Z : HSQ_FWD_LOW;
        end
      end
      HSQ_FWD_LOW: begin
        if (org_rise) begin
          next_state = HSQ_SEEK_Z;
        end
      end
      HSQ_SEEK_Z: begin
        if (z_rise) begin
          next_state = HSQ_DONE;
        end
      end
      HSQ_DONE: begin
        if (!START_I) begin
          next_state = HSQ_IDLE;
        end
      end
      default: next_state = HSQ_IDLE;
    endcase
  end

  // motion command follows the state entered; seek z keeps the previous direction
  always_comb begin
    next_motion = HSQ_MOTION_RST;
    case (next_state)
      HSQ_FWD_HIGH: next_motion = '{run: 1'b1, reverse: 1'b0, speed: SPEED_HIGH_I};
      HSQ_REV_HIGH: next_motion = '{run: 1'b1, reverse: 1'b1, speed: SPEED_HIGH_I};
      HSQ_REV_LOW:  next_motion = '{run: 1'b1, reverse: 1'b1, speed: SPEED_LOW_I};
      HSQ_FWD_LOW:  next_motion = '{run: 1'b1, reverse: 1'b0, speed: SPEED_LOW_I};
      HSQ_SEEK_Z:   next_motion = '{run: 1'b1, reverse: REVERSE_O, speed: SPEED_LOW_I};
      default:      next_motion = HSQ_MOTION_RST;
    endcase
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      state     <= HSQ_IDLE;
      RUN_O     <= 1'b0;
      REVERSE_O <= 1'b0;
      SPEED_O   <= '0;
      BUSY_O    <= 1'b0;
      DONE_O    <= 1'b0;
    end else begin
      state     <= next_state;
      RUN_O     <= next_motion.run;
      REVERSE_O <= next_motion.reverse;
      SPEED_O   <= next_motion.speed;
      BUSY_O    <= (next_state != HSQ_IDLE) && (next_state != HSQ_DONE);
      DONE_O    <= (next_state == HSQ_DONE);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_m7_fwd_high;
    state == HSQ_FWD_HIGH && is_m7;
  endsequence

  sequence s_m7_seek;
    state == HSQ_SEEK_Z && is_m7;
  endsequence

  sequence s_m8_seek;
    state == HSQ_SEEK_Z && !is_m7;
  endsequence

  sequence s_high_phase;
    state == HSQ_FWD_HIGH || state == HSQ_REV_HIGH;
  endsequence

  sequence s_low_phase;
    state == HSQ_REV_LOW || state == HSQ_FWD_LOW || state == HSQ_SEEK_Z;
  endsequence

  limit_reverse_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    s_m7_fwd_high ##0 (lim_rise && !org_rise) |=> (RUN_O && REVERSE_O && SPEED_O == $past(SPEED_HIGH_I)))
    else $error("limit did not reverse at high speed");

  drop_low_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (state == HSQ_REV_HIGH && org_rise) |=> (REVERSE_O && SPEED_O == $past(SPEED_LOW_I)))
    else $error("reverse high did not drop to low");

  m7_stop_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    s_m7_seek ##0 z_rise |=> (DONE_O && !RUN_O && !BUSY_O))
    else $error("method 7 did not stop on z");

  m8_rev_low_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (state == HSQ_FWD_HIGH && !is_m7 && org_rise) |=> (state == HSQ_REV_LOW && REVERSE_O))
    else $error("method 8 did not reverse low");

  fwd_low_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (state == HSQ_REV_LOW && !is_m7 && org_fall) |=> (state == HSQ_FWD_LOW && !REVERSE_O))
    else $error("falling edge did not go forward low");

  z_after_rise_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (state == HSQ_FWD_LOW && z_rise && !org_rise) |=> (state == HSQ_FWD_LOW && RUN_O))
    else $error("stopped on z before origin rise");

  direct_low_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (state == HSQ_IDLE && start_ok && METHOD_I == HSQ_METHOD_8 && DECEL_VALID_I)
      |=> (state == HSQ_REV_LOW && SPEED_O == $past(SPEED_LOW_I)))
    else $error("valid decel point did not start low");

  seek_stop_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    s_m8_seek ##0 z_rise |=> (DONE_O && !RUN_O && SPEED_O == '0))
    else $error("no stop after origin rise and z");

  edge_once_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    org_rise |=> !org_rise)
    else $error("origin edge seen twice");

  lim_once_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    lim_rise |=> !lim_rise)
    else $error("limit edge seen twice");

  high_speed_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    s_high_phase |-> (RUN_O && SPEED_O == $past(SPEED_HIGH_I)))
    else $error("high phase not at first homing speed");

  low_speed_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    s_low_phase |-> (RUN_O && SPEED_O == $past(SPEED_LOW_I)))
    else $error("low phase not at second homing speed");

  m8_fwd_low_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (state == HSQ_REV_LOW && !is_m7 && org_fall)
      |=> (RUN_O && !REVERSE_O && SPEED_O == $past(SPEED_LOW_I)))
    else $error("falling edge did not give forward low speed");

  m7_z_early_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (state == HSQ_REV_LOW && is_m7 && z_rise && !org_fall)
      |=> (state == HSQ_REV_LOW && RUN_O))
    else $error("method 7 stopped on z before origin fall");

  m7_hold_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    s_m7_seek ##0 !z_rise |=> (state == HSQ_SEEK_Z && RUN_O && REVERSE_O))
    else $error("method 7 left z seek without z");

  m8_hold_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    s_m8_seek ##0 !z_rise |=> (state == HSQ_SEEK_Z && RUN_O && !REVERSE_O))
    else $error("method 8 left z seek without z");

endmodule : hsq_homing_seq

// ### design/hsq_pkg.sv
// Overview of operation
// - high speed uses first homing speed to find decel point; low speed finds origin
// - method 7.3 starts forward high; forward limit before origin reverses at high speed
// - method 7.3 reverse high drops to reverse low on origin switch rising edge
// - method 7.3 stops on first Z pulse after origin switch falling edge
// - method 8.1 starts forward high; origin rising edge switches to reverse low
// - method 8.1 reverse low switches to forward low on origin falling edge
// - method 8.1 stops on first Z pulse after origin rising edge
// - method 8.2 with valid decel point starts directly at reverse low speed
// - method 8.2 changes to forward low speed on origin switch falling edge
// - method 8.2 forward low stops on first Z pulse after origin rising edge
package hsq_pkg;

  // ----------------------------------------
  // commands and states
  // ----------------------------------------
  localparam logic [3:0] HSQ_METHOD_7 = 4'h7;
  localparam logic [3:0] HSQ_METHOD_8 = 4'h8;
  localparam int         HSQ_SPEED_W  = 32;

  typedef enum logic [2:0] {
    HSQ_IDLE     = 3'b000,
    HSQ_FWD_HIGH = 3'b001,
    HSQ_REV_HIGH = 3'b010,
    HSQ_REV_LOW  = 3'b011,
    HSQ_FWD_LOW  = 3'b100,
    HSQ_SEEK_Z   = 3'b101,
    HSQ_DONE     = 3'b110
  } hsq_state_t;

  typedef struct packed {
    logic                   run;
    logic                   reverse;
    logic [HSQ_SPEED_W-1:0] speed;
  } hsq_motion_t;

  localparam hsq_motion_t HSQ_MOTION_RST = '{run: 1'b0, reverse: 1'b0, speed: '0};

endpackage : hsq_pkg

// ### verification/hsq_axis_model.sv
module hsq_axis_model
  import hsq_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   load_i,
  input  wire logic [15:0]            load_pos_i,
  input  wire logic                   run_i,
  input  wire logic                   reverse_i,
  input  wire logic [HSQ_SPEED_W-1:0] speed_i,
  output logic                        origin_sw_o,
  output logic                        fwd_limit_o,
  output logic                        z_phase_o,
  output logic [15:0]                 pos_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // axis position
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pos_o <= 16'h0000;
    end else if (load_i) begin
      pos_o <= load_pos_i;
    end else if (run_i) begin
      pos_o <= reverse_i ? pos_o - speed_i[15:0] : pos_o + speed_i[15:0];
    end
  end

  // ----------------------------------------
  // switches and index marks
  // ----------------------------------------
  // steps above 4 per cycle could jump over an index window
  assign origin_sw_o = (pos_o >= 16'h00c8) && (pos_o <= 16'h012b);
  assign fwd_limit_o = pos_o >= 16'h0258;
  assign z_phase_o   = pos_o[5:0] < 6'h04;
endmodule : hsq_axis_model

// ### verification/test_homing_sequencer_modes_7_8.sv
module test_homing_sequencer_modes_7_8 import hsq_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] HI = 32'h00000004;
  localparam logic [31:0] LO = 32'h00000001;
  logic        clk = 1'b0, rst = 1'b1, start = 1'b0, decel = 1'b0, load = 1'b0;
  logic [3:0]  method = 4'h0;
  logic [15:0] lpos = 16'h0000, pos;
  logic        run, rev, busy, done, org, lim, z;
  logic        prev_run = 1'b0, prev_rev = 1'b0, saw_hi = 1'b0, bad_spd = 1'b0, bad_busy = 1'b0;
  logic [31:0] speed;
  int          n_fail = 0, checks = 0, flips = 0;

`define CHK(a, e, m) begin checks++; if ((a) !== (e)) begin n_fail++; \
  $display("CHECK FAILED at %0t: %s", $time, m); end end

  always #2.5 clk = ~clk;

  hsq_homing_seq DUT (.CLK_SYS_I(clk), .RST_I(rst), .START_I(start), .METHOD_I(method),
    .DECEL_VALID_I(decel), .SPEED_HIGH_I(HI), .SPEED_LOW_I(LO), .ORIGIN_SW_I(org),
    .FWD_LIMIT_I(lim), .Z_PHASE_I(z), .RUN_O(run), .REVERSE_O(rev), .SPEED_O(speed),
    .BUSY_O(busy), .DONE_O(done));
  hsq_axis_model u_axis (.clk_i(clk), .rst_i(rst), .load_i(load), .load_pos_i(lpos),
    .run_i(run), .reverse_i(rev), .speed_i(speed), .origin_sw_o(org),
    .fwd_limit_o(lim), .z_phase_o(z), .pos_o(pos));

  // ----------------------------------------
  // phase monitor
  // ----------------------------------------
  // falling edge keeps clear of the registered output updates
  // flags clear here between runs so each has a single writer
  always @(negedge clk) begin
    if (start !== 1'b1) begin
      flips = 0;
      saw_hi = 1'b0;
      bad_spd = 1'b0;
      bad_busy = 1'b0;
    end else begin
      if (busy !== run) bad_busy = 1'b1;
      if (run === 1'b1 && speed !== HI && speed !== LO) bad_spd = 1'b1;
      if (run === 1'b1 && speed === HI) saw_hi = 1'b1;
      if (run === 1'b1 && prev_run === 1'b1 && rev !== prev_rev) flips++;
    end
    prev_run = run;
    prev_rev = rev;
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic go(input logic [3:0] m, input logic d, input logic [15:0] p);
    int n;
    @(posedge clk);
    #1 load = 1'b1;
    lpos = p;
    method = m;
    decel = d;
    @(posedge clk);
    #1 load = 1'b0;
    start = 1'b1;
    n = 0;
    while (done !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    #1;
  endtask : go

  task automatic t_m82;
    go(4'h8, 1'b1, 16'h00fa);
    `CHK({run, busy, done, speed}, {3'b001, 32'h0}, "8.2 stop")
    `CHK(pos >= 16'h0100 && pos <= 16'h0103, 1'b1, "8.2 stop place")
    `CHK({flips == 1, saw_hi, bad_busy}, 3'b100, "8.2 phases")
    start = 1'b0;
    repeat (2) @(posedge clk);
  endtask : t_m82

  task automatic t_m81;
    go(4'h8, 1'b0, 16'h0064);
    `CHK({run, busy, done, speed}, {3'b001, 32'h0}, "8.1 stop")
    `CHK(pos >= 16'h0100 && pos <= 16'h0103, 1'b1, "8.1 stop place")
    `CHK({flips == 2, saw_hi, bad_busy}, 3'b110, "8.1 phases")
    `CHK(bad_spd, 1'b0, "speed value")
    start = 1'b0;
    repeat (2) @(posedge clk);
  endtask : t_m81

  task automatic t_m73;
    go(4'h7, 1'b0, 16'h0190);
    `CHK({run, busy, done, speed}, {3'b001, 32'h0}, "7.3 stop")
    `CHK(pos >= 16'h00bf && pos <= 16'h00c3, 1'b1, "7.3 stop place")
    `CHK({flips == 1, saw_hi, bad_spd}, 3'b110, "7.3 phases")
    start = 1'b0;
    repeat (2) @(posedge clk);
  endtask : t_m73

  task automatic end_of_test;
    $display("fails %0d checks %0d", n_fail, checks);
    if (n_fail == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    t_m82();
    t_m81();
    t_m73();
    end_of_test();
  end

  initial begin
    #50000;
    n_fail++;
    end_of_test();
  end
endmodule : test_homing_sequencer_modes_7_8
